// ### core/dtr_top.v
// Purpose: transform readout, clock select and temperature control core
// Assumes: host reaches registers over a two-wire serial port on pins
// Notes:   serial clock is sampled by MCLK_I, so it must be well slower
//
// Overview of operation
// - gain bit selects receive gain five or one
// - ADC codes go straight into accumulator
// - accumulate sample times cosine and negated sine
// - results are two signed 16-bit words
// - real at 0x94/0x95, imaginary at 0x96/0x97
// - clock-source bit picks internal or external clock
// - internal oscillator is selected after reset
// - internal oscillator nominally runs at 16.776 MHz
// - temperature conversion timed internally
// - temperature block powered down after reset
// - conversion ends after 800 us, then powers down
// - status flags valid temperature; host polls it
// - temperature read-only at 0x92/0x93, 14-bit code
// - code resolution is one thirty-second degree
// - example encodings follow the sensor code directly
// - status bit set when transform results valid
`timescale 1ns/1ps
`default_nettype none
`include "dtr_defines.vh"

module dtr_top #(
   parameter TEMP_CONV_CYCLES = `DTR_TEMP_CONV_CYCLES,
   parameter [6:0] DEV_ADDR = `DTR_DEV_ADDR,
   parameter N_SAMPLES = `DTR_DFT_SAMPLES
)(
   input wire MCLK_I,
   input wire RESETN_I,
   input wire CE_I,
   input wire SCL_I,
   input wire SDA_I,
   output wire SDA_O,
   output reg SDA_OE_O,
   input wire ADC_VALID_I,
   input wire [`DTR_ADC_W-1:0] ADC_DATA_I,
   input wire signed [`DTR_VEC_W-1:0] COS_I,
   input wire signed [`DTR_VEC_W-1:0] SIN_I,
   input wire [13:0] TEMP_CODE_I,
   output reg TEMP_PWR_O,
   output reg PGA_GAIN5_O,
   output reg CLK_SEL_EXT_O
);
   // ***************************************************
   // serial pin synchronisers and edge finding
   // ***************************************************
   reg scl_s1, scl_s2, scl_s3;
   reg sda_s1, sda_s2, sda_s3;

   always @(posedge MCLK_I)
   begin
      if (!RESETN_I)
      begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_s3 <= 1'b1;
      end
      else if (CE_I)
      begin
         scl_s1 <= SCL_I;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         sda_s1 <= SDA_I;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
      end
   end

   wire scl_rise = scl_s2 & ~scl_s3;
   wire scl_fall = ~scl_s2 & scl_s3;
   wire start_det = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
   wire stop_det = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;

   // open drain: only ever pulls low
   assign SDA_O = 1'b0;

   // ***************************************************
   // register state
   // ***************************************************
   reg [7:0] ctrl_hi;
   reg temp_valid;
   reg dft_valid;
   reg [15:0] temp_result;
   reg [14:0] temp_cnt;
   wire signed [`DTR_RES_W-1:0] dft_real;
   wire signed [`DTR_RES_W-1:0] dft_imag;
   wire dft_done;

   function [7:0] rd_byte;
      input [7:0] a;
      input [7:0] hi;
      input [7:0] lo;
      input [7:0] st;
      input [15:0] t;
      input [15:0] re;
      input [15:0] im;
      begin
         case (a)
            `DTR_REG_CTRL_HI: rd_byte = hi;
            `DTR_REG_CTRL_LO: rd_byte = lo;
            `DTR_REG_STATUS: rd_byte = st;
            `DTR_REG_TEMP_HI: rd_byte = t[15:8];
            `DTR_REG_TEMP_LO: rd_byte = t[7:0];
            `DTR_REG_REAL_HI: rd_byte = re[15:8];
            `DTR_REG_REAL_LO: rd_byte = re[7:0];
            `DTR_REG_IMAG_HI: rd_byte = im[15:8];
            `DTR_REG_IMAG_LO: rd_byte = im[7:0];
            default: rd_byte = 8'h00;
         endcase
      end
   endfunction

   // ***************************************************
   // serial slave state machine
   // ***************************************************
   localparam [6:0] S_IDLE = 7'b0000001;
   localparam [6:0] S_ADDR = 7'b0000010;
   localparam [6:0] S_AACK = 7'b0000100;
   localparam [6:0] S_WR = 7'b0001000;
   localparam [6:0] S_WACK = 7'b0010000;
   localparam [6:0] S_RD = 7'b0100000;
   localparam [6:0] S_RACK = 7'b1000000;

   reg [6:0] state;
   reg [3:0] bit_cnt;
   reg [7:0] rx_sh;
   reg [7:0] tx_sh;
   reg [7:0] ptr;
   reg rw;
   reg first;
   reg host_nack;
   reg wr_en;
   reg [7:0] wr_addr;
   reg [7:0] wr_data;

   wire [7:0] status = {5'h00, dft_valid, 1'b0, temp_valid};
   wire [7:0] ctrl_lo = {4'h0, CLK_SEL_EXT_O, 3'h0};
   wire [7:0] rd_now = rd_byte(ptr, ctrl_hi, ctrl_lo, status,
                               temp_result, dft_real, dft_imag);

   always @(posedge MCLK_I)
   begin
      if (!RESETN_I)
      begin
         state <= S_IDLE;
         bit_cnt <= 4'h0;
         rx_sh <= 8'h00;
         tx_sh <= 8'h00;
         ptr <= 8'h00;
         rw <= 1'b0;
         first <= 1'b0;
         host_nack <= 1'b0;
         wr_en <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
         SDA_OE_O <= 1'b0;
      end
      else if (CE_I)
      begin
         wr_en <= 1'b0;
         if (start_det)
         begin
            state <= S_ADDR;
            bit_cnt <= 4'h0;
            SDA_OE_O <= 1'b0;
         end
         else if (stop_det)
         begin
            state <= S_IDLE;
            SDA_OE_O <= 1'b0;
         end
         else
         begin
            case (state)
               S_IDLE:
               begin
                  SDA_OE_O <= 1'b0;
               end
               S_ADDR:
               begin
                  if (scl_rise)
                  begin
                     rx_sh <= {rx_sh[6:0], sda_s2};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
                  else if (scl_fall && bit_cnt == 4'h8)
                  begin
                     if (rx_sh[7:1] == DEV_ADDR)
                     begin
                        rw <= rx_sh[0];
                        first <= ~rx_sh[0];
                        SDA_OE_O <= 1'b1;
                        state <= S_AACK;
                     end
                     else
                        state <= S_IDLE;
                  end
               end
               S_AACK:
               begin
                  if (scl_fall)
                  begin
                     bit_cnt <= 4'h0;
                     if (rw)
                     begin
                        tx_sh <= rd_now;
                        SDA_OE_O <= ~rd_now[7];
                        ptr <= ptr + 8'h01;
                        state <= S_RD;
                     end
                     else
                     begin
                        SDA_OE_O <= 1'b0;
                        state <= S_WR;
                     end
                  end
               end
               S_WR:
               begin
                  if (scl_rise)
                  begin
                     rx_sh <= {rx_sh[6:0], sda_s2};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
                  else if (scl_fall && bit_cnt == 4'h8)
                  begin
                     if (first)
                        ptr <= rx_sh;
                     else
                     begin
                        wr_en <= 1'b1;
                        wr_addr <= ptr;
                        wr_data <= rx_sh;
                        ptr <= ptr + 8'h01;
                     end
                     first <= 1'b0;
                     SDA_OE_O <= 1'b1;
                     state <= S_WACK;
                  end
               end
               S_WACK:
               begin
                  if (scl_fall)
                  begin
                     SDA_OE_O <= 1'b0;
                     bit_cnt <= 4'h0;
                     state <= S_WR;
                  end
               end
               S_RD:
               begin
                  if (scl_rise)
                     bit_cnt <= bit_cnt + 4'h1;
                  else if (scl_fall)
                  begin
                     if (bit_cnt == 4'h8)
                     begin
                        SDA_OE_O <= 1'b0;
                        state <= S_RACK;
                     end
                     else
                     begin
                        tx_sh <= {tx_sh[6:0], 1'b0};
                        SDA_OE_O <= ~tx_sh[6];
                     end
                  end
               end
               S_RACK:
               begin
                  if (scl_rise)
                     host_nack <= sda_s2;
                  else if (scl_fall)
                  begin
                     if (host_nack)
                        state <= S_IDLE;
                     else
                     begin
                        bit_cnt <= 4'h0;
                        tx_sh <= rd_now;
                        SDA_OE_O <= ~rd_now[7];
                        ptr <= ptr + 8'h01;
                        state <= S_RD;
                     end
                  end
               end
               default:
               begin
                  state <= S_IDLE;
                  SDA_OE_O <= 1'b0;
               end
            endcase
         end
      end
   end

   // ***************************************************
   // control register and command decode
   // ***************************************************
   wire cmd_wr = wr_en && wr_addr == `DTR_REG_CTRL_HI;
   wire [3:0] cmd = wr_data[`DTR_CMD_MSB:`DTR_CMD_LSB];
   wire dft_start = cmd_wr && (cmd == `DTR_CMD_START ||
                    cmd == `DTR_CMD_INCR || cmd == `DTR_CMD_REPEAT);
   wire temp_start = cmd_wr && cmd == `DTR_CMD_TEMP;

   always @(posedge MCLK_I)
   begin
      if (!RESETN_I)
      begin
         ctrl_hi <= `DTR_CTRL_HI_RST;
         PGA_GAIN5_O <= 1'b0;
         CLK_SEL_EXT_O <= 1'b0;
      end
      else if (CE_I && wr_en)
      begin
         if (wr_addr == `DTR_REG_CTRL_HI)
         begin
            ctrl_hi <= wr_data;
            // low means gain five, high means unity
            PGA_GAIN5_O <= ~wr_data[`DTR_GAIN_BIT];
         end
         if (wr_addr == `DTR_REG_CTRL_LO)
            // downstream mux switches to the 16.776 MHz oscillator when low
            CLK_SEL_EXT_O <= wr_data[`DTR_CLKSRC_BIT];
      end
   end

   // ***************************************************
   // temperature conversion sequencer
   // ***************************************************
   always @(posedge MCLK_I)
   begin
      if (!RESETN_I)
      begin
         TEMP_PWR_O <= 1'b0;
         temp_cnt <= 15'h0000;
         temp_valid <= 1'b0;
         temp_result <= 16'h0000;
      end
      else if (CE_I)
      begin
         if (temp_start)
         begin
            TEMP_PWR_O <= 1'b1;
            temp_cnt <= 15'h0000;
            temp_valid <= 1'b0;
         end
         else if (TEMP_PWR_O)
         begin
            // local count, no serial clock needed during conversion
            temp_cnt <= temp_cnt + 15'h0001;
            if (temp_cnt == TEMP_CONV_CYCLES[14:0] - 15'h0001)
            begin
               TEMP_PWR_O <= 1'b0;
               // sensor code kept verbatim: 1/32 degree, bit 13 sign
               temp_result <= {2'b00, TEMP_CODE_I};
               temp_valid <= 1'b1;
            end
         end
      end
   end

   // ***************************************************
   // transform engine and its status flag
   // ***************************************************
   dtr_dft #(
      .N_SAMPLES(N_SAMPLES)
   ) u_dft (
      .clk_i(MCLK_I),
      .rst_n_i(RESETN_I),
      .ce_i(CE_I),
      .start_i(dft_start),
      .sample_valid_i(ADC_VALID_I),
      .sample_i(ADC_DATA_I),
      .cos_i(COS_I),
      .sin_i(SIN_I),
      .real_o(dft_real),
      .imag_o(dft_imag),
      .done_o(dft_done),
      .busy_o()
   );

   always @(posedge MCLK_I)
   begin
      if (!RESETN_I)
         dft_valid <= 1'b0;
      else if (CE_I)
      begin
         // a finishing point wins over a clearing start
         if (dft_done)
            dft_valid <= 1'b1;
         else if (dft_start)
            dft_valid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### core/dtr_defines.vh
// Purpose: constants for the transform and temperature readout core
// Assumes: 20 MHz core clock
// Notes:   offsets are byte addresses on the two-wire serial port
`ifndef DTR_DEFINES_VH
`define DTR_DEFINES_VH

// ***************************************************
// register offsets
// ***************************************************
`define DTR_REG_CTRL_HI 8'h80
`define DTR_REG_CTRL_LO 8'h81
`define DTR_REG_STATUS 8'h8F
`define DTR_REG_TEMP_HI 8'h92
`define DTR_REG_TEMP_LO 8'h93
`define DTR_REG_REAL_HI 8'h94
`define DTR_REG_REAL_LO 8'h95
`define DTR_REG_IMAG_HI 8'h96
`define DTR_REG_IMAG_LO 8'h97

// ***************************************************
// field positions and reset values
// ***************************************************
`define DTR_CMD_MSB 7
`define DTR_CMD_LSB 4
`define DTR_GAIN_BIT 0
`define DTR_CLKSRC_BIT 3
`define DTR_STAT_TEMP_BIT 0
`define DTR_STAT_DFT_BIT 2
`define DTR_CTRL_HI_RST 8'h00
`define DTR_CTRL_LO_RST 8'h00

// ***************************************************
// command codes (upper nibble of control high byte)
// ***************************************************
`define DTR_CMD_START 4'h2
`define DTR_CMD_INCR 4'h3
`define DTR_CMD_REPEAT 4'h4
`define DTR_CMD_TEMP 4'h9

// ***************************************************
// timing
// ***************************************************
`define DTR_CLK_PERIOD_NS 50
`define DTR_TEMP_CONV_US 800
`define DTR_TEMP_CONV_CYCLES ((`DTR_TEMP_CONV_US * 1000) / `DTR_CLK_PERIOD_NS)
`define DTR_OSC_NOMINAL_HZ 16776000
`define DTR_DFT_SAMPLES 1024
`define DTR_ADC_W 12
`define DTR_VEC_W 16
`define DTR_RES_W 16
`define DTR_RES_LSB 22
// serial bus address: the value is arbitrary, override per system
`define DTR_DEV_ADDR 7'h2A

`endif

// ### core/dtr_dft.v
// Purpose: single-bin transform accumulator for one frequency point
// Assumes: samples and test vectors arrive together on a valid strobe
// Notes:   results hold through the next start until that point's last sample
`timescale 1ns/1ps
`default_nettype none
`include "dtr_defines.vh"

module dtr_dft #(
   parameter ADC_W = `DTR_ADC_W,
   parameter VEC_W = `DTR_VEC_W,
   parameter RES_W = `DTR_RES_W,
   parameter RES_LSB = `DTR_RES_LSB,
   parameter N_SAMPLES = `DTR_DFT_SAMPLES
)(
   input wire clk_i,
   input wire rst_n_i,
   input wire ce_i,
   input wire start_i,
   input wire sample_valid_i,
   input wire [ADC_W-1:0] sample_i,
   input wire signed [VEC_W-1:0] cos_i,
   input wire signed [VEC_W-1:0] sin_i,
   output reg signed [RES_W-1:0] real_o,
   output reg signed [RES_W-1:0] imag_o,
   output reg done_o,
   output reg busy_o
);
   localparam ACC_W = ADC_W + VEC_W + 12;
   localparam [10:0] LAST = N_SAMPLES - 1;

   reg signed [ACC_W-1:0] acc_re;
   reg signed [ACC_W-1:0] acc_im;
   reg [10:0] cnt;
   // raw code enters unchanged; zero extension keeps it non-negative
   wire signed [ADC_W:0] x = {1'b0, sample_i};
   wire signed [ADC_W+VEC_W:0] p_re = x * cos_i;
   wire signed [ADC_W+VEC_W:0] p_im = x * sin_i;
   wire signed [ACC_W-1:0] next_re = acc_re + p_re;
   wire signed [ACC_W-1:0] next_im = acc_im - p_im;

   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         acc_re <= {ACC_W{1'b0}};
         acc_im <= {ACC_W{1'b0}};
         cnt <= 11'h000;
         real_o <= {RES_W{1'b0}};
         imag_o <= {RES_W{1'b0}};
         done_o <= 1'b0;
         busy_o <= 1'b0;
      end
      else if (ce_i)
      begin
         done_o <= 1'b0;
         if (start_i)
         begin
            acc_re <= {ACC_W{1'b0}};
            acc_im <= {ACC_W{1'b0}};
            cnt <= 11'h000;
            busy_o <= 1'b1;
         end
         else if (busy_o && sample_valid_i)
         begin
            acc_re <= next_re;
            acc_im <= next_im;
            cnt <= cnt + 11'h001;
            if (cnt == LAST)
            begin
               // results move only here, so byte reads stay coherent
               real_o <= next_re[RES_LSB+RES_W-1:RES_LSB];
               imag_o <= next_im[RES_LSB+RES_W-1:RES_LSB];
               done_o <= 1'b1;
               busy_o <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### testbench/dtr_checker.sv
// Purpose: port assertions for the readout core
// Assumes: one clock domain; CE_I low freezes the conversion count
// Notes: register side effects must sit inside an ack window
`timescale 1ns/1ps
`default_nettype none
module dtr_checker #(
   parameter TEMP_CONV_CYCLES = 16000
)(
   input wire logic MCLK_I,
   input wire logic RESETN_I,
   input wire logic CE_I,
   input wire logic SCL_I,
   input wire logic SDA_OE_O,
   input wire logic TEMP_PWR_O,
   input wire logic PGA_GAIN5_O,
   input wire logic CLK_SEL_EXT_O
);
   // ***************************************************
   // helper count of powered cycles
   // ***************************************************
   integer on_cnt;
   always @(posedge MCLK_I)
   begin
      if (!RESETN_I || !TEMP_PWR_O)
         on_cnt <= 0;
      else if (CE_I)
         on_cnt <= on_cnt + 1;
   end
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RESETN_I);
   a_conv_length: assert property (
      $fell(TEMP_PWR_O) |-> on_cnt == TEMP_CONV_CYCLES)
      else $error("conversion length wrong");
   a_pwr_rest: assert property (
      $fell(TEMP_PWR_O) |=> !TEMP_PWR_O [*8])
      else $error("sensor powered again without command");
   a_pwr_on_cmd: assert property (
      $rose(TEMP_PWR_O) |-> $past(SDA_OE_O))
      else $error("sensor powered outside a write");
   a_gain_on_write: assert property (
      $changed(PGA_GAIN5_O) |-> $past(SDA_OE_O))
      else $error("gain moved outside a write");
   a_clk_on_write: assert property (
      $changed(CLK_SEL_EXT_O) |-> $past(SDA_OE_O))
      else $error("clock select moved outside a write");
   a_reset_quiet: assert property (disable iff (1'b0)
      !RESETN_I && CE_I |=> !TEMP_PWR_O && !CLK_SEL_EXT_O &&
      !PGA_GAIN5_O && !SDA_OE_O)
      else $error("outputs not quiet after reset");
   a_sda_scl_low: assert property (
      $changed(SDA_OE_O) |-> !SCL_I)
      else $error("data line moved while serial clock high");
   a_ack_stands: assert property (
      $rose(SDA_OE_O) |=> SDA_OE_O [*3])
      else $error("data line drive too short");
   c_conv_done: cover property ($fell(TEMP_PWR_O));
   c_clk_ext: cover property ($rose(CLK_SEL_EXT_O));
   c_gain5: cover property ($rose(PGA_GAIN5_O));
endmodule
bind dtr_top dtr_checker #(
   .TEMP_CONV_CYCLES(TEMP_CONV_CYCLES)
) u_dtr_checker (
   .MCLK_I(MCLK_I),
   .RESETN_I(RESETN_I),
   .CE_I(CE_I),
   .SCL_I(SCL_I),
   .SDA_OE_O(SDA_OE_O),
   .TEMP_PWR_O(TEMP_PWR_O),
   .PGA_GAIN5_O(PGA_GAIN5_O),
   .CLK_SEL_EXT_O(CLK_SEL_EXT_O)
);
`default_nettype wire

// ### testbench/dtr_host.sv
// Purpose: two-wire serial host driving the register port
// Assumes: 400 ns bit time, open-drain data with pull-up
// Notes: counts missing acknowledges in nacks
`timescale 1ns/1ps
`default_nettype none
module dtr_host #(
   parameter [6:0] ADDR = 7'h2A
)(
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   // ***************************************************
   // bus cycles
   // ***************************************************
   integer nacks = 0;
   initial
   begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // data moves a cycle after the fall, so it never races the clock
   task automatic bit_io(input logic b, output logic r);
      @(posedge clk_i);
      sda_low_o <= !b;
      repeat (3) @(posedge clk_i);
      scl_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      r = sda_i;
      scl_o <= 1'b0;
   endtask
   // start (stp low) or stop (stp high) condition
   task automatic cond(input logic stp);
      @(posedge clk_i);
      sda_low_o <= stp;
      repeat (3) @(posedge clk_i);
      scl_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sda_low_o <= !stp;
      repeat (4) @(posedge clk_i);
      scl_o <= stp;
   endtask
   task automatic xfer(input logic [7:0] d, input logic ak,
                       input logic chk, output logic [7:0] q);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(ak, r);
      if (chk)
         nacks += r;
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
      logic [7:0] q;
      cond(1'b0);
      xfer({ADDR, 1'b0}, 1'b1, 1'b1, q);
      xfer(ptr, 1'b1, 1'b1, q);
      xfer(d, 1'b1, 1'b1, q);
      cond(1'b1);
   endtask
   task automatic rd(input logic [7:0] ptr, output logic [15:0] v);
      logic [7:0] q;
      cond(1'b0);
      xfer({ADDR, 1'b0}, 1'b1, 1'b1, q);
      xfer(ptr, 1'b1, 1'b1, q);
      cond(1'b0);
      xfer({ADDR, 1'b1}, 1'b1, 1'b1, q);
      xfer(8'hFF, 1'b0, 1'b0, v[15:8]);
      xfer(8'hFF, 1'b1, 1'b0, v[7:0]);
      cond(1'b1);
   endtask
   task automatic poll(input int b, output logic ok);
      logic [15:0] v;
      ok = 1'b0;
      for (int n = 0; n < 20 && !ok; n++)
      begin
         rd(8'h8F, v);
         ok = v[8 + b];
      end
   endtask
endmodule
`default_nettype wire

// ### testbench/dtr_top_tb.sv
// Purpose: self-checking bench for the readout core
// Assumes: shortened conversion and sample counts
// Notes: expected values are rebuilt from the documented formats
`timescale 1ns/1ps
`default_nettype none
module dtr_top_tb;
   // ***************************************************
   // signals and instances
   // ***************************************************
   localparam CONV = 1000;
   localparam NS = 8;
   localparam LIMIT = 60000;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic adc_valid = 1'b0;
   logic [11:0] adc_data = 12'h000;
   logic [15:0] cos_v = 16'h0000;
   logic [15:0] sin_v = 16'h0000;
   logic [13:0] temp_code = 14'h0000;
   logic [15:0] rnd = 16'h57D2;
   logic [15:0] v;
   logic [15:0] prev_re;
   logic ok;
   wire scl;
   wire host_low;
   wire sda_o;
   wire sda_oe;
   wire temp_pwr;
   wire gain5;
   wire clk_ext;
   wire sda = (sda_oe ? sda_o : 1'b1) & !host_low;
   integer err_count = 0;
   integer compares = 0;
   integer cycles = 0;
   int d, x, c, s;
   longint are, aim;
   int tab [5] = '{-1280, 800, 0, -1, 4800};
   dtr_top #(
      .TEMP_CONV_CYCLES(CONV),
      .N_SAMPLES(NS)
   ) u_dtr_top (
      .MCLK_I(clk),
      .RESETN_I(rst_n),
      .CE_I(ce),
      .SCL_I(scl),
      .SDA_I(sda),
      .SDA_O(sda_o),
      .SDA_OE_O(sda_oe),
      .ADC_VALID_I(adc_valid),
      .ADC_DATA_I(adc_data),
      .COS_I(cos_v),
      .SIN_I(sin_v),
      .TEMP_CODE_I(temp_code),
      .TEMP_PWR_O(temp_pwr),
      .PGA_GAIN5_O(gain5),
      .CLK_SEL_EXT_O(clk_ext)
   );
   dtr_host u_dtr_host (
      .clk_i(clk),
      .sda_i(sda),
      .scl_o(scl),
      .sda_low_o(host_low)
   );
   always #25 clk = ~clk;
   function automatic logic [15:0] lfsr(input logic [15:0] q);
      return {q[14:0], q[15] ^ q[13] ^ q[12] ^ q[10]};
   endfunction
   // sensor code from a reading in 1/32 degree steps
   function automatic logic [13:0] tcode(input int t32);
      return 14'(t32 < 0 ? t32 + 16384 : t32);
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         err_count++;
         results;
      end
   end
   // ***************************************************
   // scenarios
   // ***************************************************
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      check({13'h0, clk_ext, gain5, temp_pwr}, 16'h0000);
      u_dtr_host.rd(8'h8F, v);
      check(v, 16'h0000);
      u_dtr_host.wr(8'h81, 8'h08);
      check({13'h0, clk_ext, gain5, temp_pwr}, 16'h0004);
      u_dtr_host.wr(8'h80, 8'h00);
      check({13'h0, clk_ext, gain5, temp_pwr}, 16'h0006);
      u_dtr_host.wr(8'h80, 8'h01);
      check({13'h0, clk_ext, gain5, temp_pwr}, 16'h0004);
      u_dtr_host.wr(8'h81, 8'h00);
      check({13'h0, clk_ext, gain5, temp_pwr}, 16'h0000);
      for (int i = 0; i < 6; i++)
      begin
         d = tab[i % 5];
         if (i == 5)
            d = $signed(rnd[12:0]);
         rnd = lfsr(rnd);
         // sensor output only counts on the last conversion cycle
         temp_code <= ~tcode(d);
         u_dtr_host.wr(8'h80, 8'h91);
         check({15'h0, temp_pwr}, 16'h0001);
         if (i == 0)
         begin
            // a frozen core must not finish the conversion on its own
            ce <= 1'b0;
            repeat (1500) @(posedge clk);
            check({15'h0, temp_pwr}, 16'h0001);
            ce <= 1'b1;
         end
         u_dtr_host.rd(8'h8F, v);
         check({15'h0, v[8]}, 16'h0000);
         temp_code <= tcode(d);
         u_dtr_host.poll(0, ok);
         check({14'h0, ok, temp_pwr}, 16'h0002);
         u_dtr_host.wr(8'h92, 8'hFF);
         u_dtr_host.rd(8'h92, v);
         check(v, {2'b00, tcode(d)});
      end
      for (int p = 0; p < 3; p++)
      begin
         if (p > 0)
         begin
            u_dtr_host.rd(8'h94, v);
            check(v, prev_re);
         end
         u_dtr_host.wr(8'h80, {4'h2 + p[3:0], 4'h1});
         are = 0;
         aim = 0;
         for (int n = 0; n < NS; n++)
         begin
            x = rnd[11:0];
            rnd = lfsr(rnd);
            c = $signed(rnd);
            rnd = lfsr(rnd);
            s = $signed(rnd);
            rnd = lfsr(rnd);
            adc_data <= x[11:0];
            cos_v <= c[15:0];
            sin_v <= s[15:0];
            adc_valid <= 1'b1;
            @(posedge clk);
            adc_valid <= 1'b0;
            @(posedge clk);
            are += x * c;
            aim -= x * s;
         end
         u_dtr_host.poll(2, ok);
         check({15'h0, ok}, 16'h0001);
         u_dtr_host.rd(8'h94, v);
         check(v, are[37:22]);
         u_dtr_host.rd(8'h96, v);
         check(v, aim[37:22]);
         prev_re = are[37:22];
      end
      check(u_dtr_host.nacks[15:0], 16'h0000);
      results;
   end
endmodule
`default_nettype wire
